// File: design/uop_pkg.sv
// Shared constants and carrier types for the transceiver link port.
// Assumes a single system clock mclk; the link clock is sampled, not used as a clock.
package uop_pkg;
  // System clock period and link clock nominal rate.
  localparam int MCLK_NS = 100;
  localparam int LINK_CLK_MHZ = 60;
  // Synchroniser depth for every pin that comes from the transceiver.
  localparam int SYNC_STAGES = 2;
  // Command byte prefixes in bits 7:6 of the first byte sent on the link.
  localparam logic [1:0] CMD_TRANSMIT = 2'h1;
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ = 2'h3;
  localparam int REG_ADDR_W = 6;
  localparam logic [7:0] DATA_IDLE = 8'h00;
  // Speed encodings.
  localparam logic [1:0] SPD_HIGH = 2'h0;
  localparam logic [1:0] SPD_FULL = 2'h1;
  localparam logic [1:0] SPD_LOW = 2'h2;
  // Capacity limits of the controller.
  localparam int MAX_HOST_CHANNELS = 16;
  localparam int MAX_DEV_ENDPOINTS = 16;
  localparam int MAX_PERIODIC_IN = 7;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] MAX_HOST_CHANNELS_C = CNT_W'(MAX_HOST_CHANNELS);
  localparam logic [CNT_W-1:0] MAX_DEV_ENDPOINTS_C = CNT_W'(MAX_DEV_ENDPOINTS);
  localparam logic [CNT_W-1:0] MAX_PERIODIC_IN_C = CNT_W'(MAX_PERIODIC_IN);
  // Reset values.
  localparam logic [1:0] SPEED_RST = SPD_FULL;

  typedef struct packed {
    logic       dir;
    logic       nxt;
    logic [7:0] data;
  } uop_link_in_t;

  typedef struct packed {
    logic       valid;
    logic       is_cmd;
    logic [7:0] data;
  } uop_rx_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_TX     = 3'h1,
    ST_STOP   = 3'h3,
    ST_REGCMD = 3'h2,
    ST_REGWR  = 3'h6,
    ST_RDWAIT = 3'h7
  } uop_state_t;
endpackage

// File: design/uop_sync_edge.sv
// Two-flop synchroniser for a vector of pins plus rising-edge detect on bit 0.
// Assumes bit 0 carries the sampled link clock; all bits share one delay.
`timescale 1ns/1ps
`default_nettype none
module uop_sync_edge
  import uop_pkg::*;
#(
  parameter int W = 12
) (
  // System.
  input wire logic mclk,
  input wire logic rst,
  // Pins.
  input wire logic [W-1:0] pin_in,
  // Synchronised view.
  output logic [W-1:0] pin_sync,
  output logic clk_rise
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic prev_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      // Held high at reset, but sync_reg also resets low, so a link clock already high at release is still taken as a rise.
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg[0];
    end
  end

  assign pin_sync = sync_reg;
  assign clk_rise = sync_reg[0] & ~prev_reg;
endmodule // uop_sync_edge
`default_nettype wire

// File: design/uop_link_port.sv
// Link side of the on-the-go controller: drives the low-pin-count transceiver bus.
// Assumes the transceiver clock is far slower than mclk so each of its edges is seen.
// Function
// (RULE1) The transceiver supplies the 60 MHz link clock and all link logic follows it.
// (RULE2) Every link signal is launched and sampled on the rising edge of the link clock.
// (RULE3) The transceiver holds direction high while it has data and low otherwise.
// (RULE4) While sending, next high means the byte on the bus was taken and the next follows.
// (RULE5) While receiving, next high marks a fresh byte valid on the bus.
// (RULE6) The controller raises stop to end each stream it sends.
// (RULE7) The controller can also raise stop to ask the transceiver for data.
// (RULE8) The controller drives all eight data lines low while the link is idle.
// (RULE9) One 8-bit byte moves per link clock, on either bus arrangement.
// (RULE10) Host role allows high, full and low speed; device role only high and full.
// (RULE11) Host role offers at most 16 channels that software may reprogram.
// (RULE12) Device role offers up to 16 endpoints with at most seven periodic IN ones.
// (RULE13) Software may read and write transceiver registers across the link.
// (RULE14) Attachment is known only from an external attach-detection controller.
// (RULE15) On direction high the bus is released with one turnaround cycle before sampling.
`timescale 1ns/1ps
`default_nettype none
module uop_link_port
  import uop_pkg::*;
(
  // System.
  input wire logic mclk,
  input wire logic rst,
  // Transceiver pins.
  input wire logic link_clk,
  input wire logic link_dir,
  input wire logic link_nxt,
  input wire logic [7:0] link_data_i,
  output logic [7:0] link_data_o,
  output logic link_data_oe,
  output logic link_stp,
  // Transmit stream; first byte is the transmit command byte.
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_take,
  output logic tx_abort,
  // Receive stream.
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_is_cmd,
  output logic rx_active,
  // Data request by stop.
  input wire logic pull_req,
  // Transceiver register access.
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic reg_done,
  output logic [7:0] reg_rdata,
  output logic reg_busy,
  // Role, speed and capacity checks.
  input wire logic host_mode,
  input wire logic [1:0] speed_req,
  input wire logic [CNT_W-1:0] chan_used,
  input wire logic [CNT_W-1:0] ep_used,
  input wire logic [CNT_W-1:0] per_in_used,
  output logic [1:0] speed_eff,
  output logic limit_err,
  // External attach detection.
  input wire logic attach_detection,
  output logic attached
);
  localparam int SW = 12;
  logic [SW-1:0] pin_sync;
  logic edge_tick;
  uop_link_in_t lin;
  uop_rx_t rx_reg;
  uop_state_t state_reg;
  logic dir_q_reg;
  logic pull_pend_reg;
  logic reg_pend_reg;
  logic rd_pend_reg;
  logic reg_write_reg;
  logic tx_last_reg;
  logic [REG_ADDR_W-1:0] reg_addr_reg;
  logic [7:0] reg_wdata_reg;

  uop_sync_edge #(
    .W(SW)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in({attach_detection, link_data_i, link_nxt, link_dir, link_clk}),
    .pin_sync(pin_sync),
    .clk_rise(edge_tick)
  );

  assign lin = uop_link_in_t'({pin_sync[1], pin_sync[2], pin_sync[SW-2:3]});

  // Command byte for a register access.
  function automatic logic [7:0] reg_cmd(input logic wr, input logic [REG_ADDR_W-1:0] a);
    reg_cmd = {(wr ? CMD_REG_WRITE : CMD_REG_READ), a};
  endfunction

  // Requests from the user side are held until the link can serve them.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pull_pend_reg <= 1'b0;
    end else if (pull_req) begin
      pull_pend_reg <= 1'b1;
    end else if (edge_tick && state_reg == ST_IDLE && !lin.dir && !dir_q_reg) begin
      pull_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_write_reg <= 1'b0;
      reg_addr_reg <= '0;
      reg_wdata_reg <= DATA_IDLE;
    end else if (reg_req && !reg_pend_reg) begin
      reg_write_reg <= reg_write;
      reg_addr_reg <= reg_addr;
      reg_wdata_reg <= reg_wdata;
    end
  end

  // Main link sequencer; apart from reg_pend_reg capture and pulse clearing, everything moves only on a sampled link clock rise.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      dir_q_reg <= 1'b0;
      link_data_o <= DATA_IDLE;
      link_data_oe <= 1'b1;
      link_stp <= 1'b0;
      reg_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      reg_done <= 1'b0;
      reg_rdata <= DATA_IDLE;
      tx_take <= 1'b0;
      tx_abort <= 1'b0;
      rx_reg <= '0;
      tx_last_reg <= 1'b0;
      rx_active <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      tx_abort <= 1'b0;
      reg_done <= 1'b0;
      rx_reg.valid <= 1'b0;
      // A request while one is pending is refused, as its fields are not captured.
      if (reg_req && !reg_pend_reg) begin
        reg_pend_reg <= 1'b1;
      end
      if (edge_tick) begin // RULE1 RULE2
        dir_q_reg <= lin.dir;
        if (lin.dir && !dir_q_reg) begin
          // Turnaround: let go of the bus and do not sample this cycle.
          link_data_oe <= 1'b0; // RULE15
          link_data_o <= DATA_IDLE;
          link_stp <= 1'b0;
          rx_active <= 1'b1;
          if (state_reg == ST_TX || state_reg == ST_STOP) begin
            tx_abort <= 1'b1;
          end
          if (state_reg == ST_RDWAIT) begin
            rd_pend_reg <= 1'b1;
          end
          state_reg <= ST_IDLE;
        end else if (lin.dir) begin // RULE3
          if (rd_pend_reg) begin
            // Register read data arrives in the first cycle after turnaround.
            reg_rdata <= lin.data; // RULE13
            reg_done <= 1'b1;
            rd_pend_reg <= 1'b0;
            reg_pend_reg <= 1'b0;
          end else begin
            rx_reg.valid <= 1'b1; // RULE5 RULE9
            rx_reg.is_cmd <= !lin.nxt;
            rx_reg.data <= lin.data;
          end
        end else if (dir_q_reg) begin
          // Turnaround back: retake the bus idle low before any command.
          link_data_oe <= 1'b1;
          link_data_o <= DATA_IDLE; // RULE8
          rx_active <= 1'b0;
        end else begin
          case (state_reg)
            ST_IDLE: begin
              link_stp <= 1'b0;
              link_data_o <= DATA_IDLE; // RULE8
              if (pull_pend_reg) begin
                link_stp <= 1'b1; // RULE7
              end else if (reg_pend_reg) begin
                link_data_o <= reg_cmd(reg_write_reg, reg_addr_reg); // RULE13
                state_reg <= ST_REGCMD;
              end else if (tx_valid) begin
                link_data_o <= tx_data; // RULE9
                tx_last_reg <= tx_last;
                tx_take <= 1'b1;
                state_reg <= ST_TX;
              end
            end
            ST_TX: begin
              // The following byte goes onto the bus at the edge that accepts the current
              // one, so the user must keep the stream valid until its last byte is out.
              if (lin.nxt) begin // RULE4
                if (tx_last_reg) begin
                  link_data_o <= DATA_IDLE;
                  link_stp <= 1'b1; // RULE6
                  state_reg <= ST_STOP;
                end else begin
                  link_data_o <= tx_data; // RULE9
                  tx_last_reg <= tx_last;
                  tx_take <= 1'b1;
                  state_reg <= ST_TX;
                end
              end
            end
            ST_STOP: begin
              link_stp <= 1'b0;
              state_reg <= ST_IDLE;
            end
            ST_REGCMD: begin
              if (lin.nxt) begin // RULE4
                link_data_o <= reg_write_reg ? reg_wdata_reg : DATA_IDLE;
                state_reg <= reg_write_reg ? ST_REGWR : ST_RDWAIT;
              end
            end
            ST_REGWR: begin
              if (lin.nxt) begin // RULE4
                link_data_o <= DATA_IDLE;
                link_stp <= 1'b1; // RULE6
                reg_done <= 1'b1;
                reg_pend_reg <= 1'b0;
                state_reg <= ST_STOP;
              end
            end
            ST_RDWAIT: begin
              link_data_o <= DATA_IDLE;
            end
            default: begin
              state_reg <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // The user updates the stream byte after each take pulse, before the next link edge.
  always_comb begin
    rx_data = rx_reg.data;
    rx_valid = rx_reg.valid;
    rx_is_cmd = rx_reg.is_cmd;
  end

  assign reg_busy = reg_pend_reg;

  // Role-dependent speed: low speed is refused in device role and falls back to full.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      speed_eff <= SPEED_RST;
    end else if (!host_mode && speed_req == SPD_LOW) begin
      speed_eff <= SPD_FULL; // RULE10
    end else if (speed_req == SPD_HIGH || speed_req == SPD_FULL || speed_req == SPD_LOW) begin
      speed_eff <= speed_req; // RULE10
    end
  end

  // Capacity check against the channel and endpoint limits of each role.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      limit_err <= 1'b0;
    end else if (host_mode) begin
      limit_err <= chan_used > MAX_HOST_CHANNELS_C; // RULE11
    end else begin
      limit_err <= (ep_used > MAX_DEV_ENDPOINTS_C) || (per_in_used > MAX_PERIODIC_IN_C); // RULE12
    end
  end

  // Attachment comes only from the external detector, never from the link itself.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      attached <= 1'b0;
    end else begin
      attached <= pin_sync[SW-1]; // RULE14
    end
  end
endmodule // uop_link_port
`default_nettype wire

// File: bench/uop_phy_model.sv
// Transceiver model: free-running link clock, byte acceptance and receive frames.
// Assumes the port drives the bus through link_data_o and link_data_oe.
`timescale 1ns/1ps
`default_nettype none
module uop_phy_model
  import uop_pkg::*;
(
  // Link pins.
  output logic link_clk,
  output logic link_dir,
  output logic link_nxt,
  output logic [7:0] link_data_i,
  input wire logic [7:0] link_data_o,
  input wire logic link_data_oe,
  input wire logic link_stp,
  // Scenario control and record of accepted bytes.
  input wire logic rx_go,
  output logic [23:0] acc_q
);
  logic [7:0] pd = 8'h00;
  logic [1:0] seq = 2'h0;
  logic rd = 1'b0;
  initial {link_clk, link_dir, link_nxt, acc_q} = '0;
  always #400 link_clk = ~link_clk;
  // A released bus shows a pattern that changes every cycle, never the last value.
  assign link_data_i = link_data_oe ? link_data_o : pd;
  // Launch 150 ns after the edge so the sampled copy still holds the old value.
  always @(posedge link_clk) begin
    if (link_nxt && !link_dir && !link_stp)
      acc_q <= {acc_q[15:0], link_data_o};
    if (seq != 2'h0) begin
      link_dir <= #150 1'b1;
      link_nxt <= #150 !rd && seq < 2'h3;
      pd <= #150 8'h50 + 8'(seq);
      seq <= seq - 2'h1;
    end else if (rx_go || (link_nxt && !link_dir && link_data_o[7:6] == CMD_REG_READ)) begin
      link_dir <= #150 1'b1;
      link_nxt <= #150 1'b0;
      seq <= rx_go ? 2'h3 : 2'h1;
      rd <= !rx_go;
    end else begin
      link_dir <= #150 1'b0;
      link_nxt <= #150 link_data_oe && link_data_o != DATA_IDLE && !link_stp;
      pd <= #150 ~pd;
    end
  end
endmodule // uop_phy_model
`default_nettype wire

// File: bench/uop_link_port_assertions.sv
// Checker for the link port: bus, stop, receive and configuration relations.
// Assumes one mclk domain with rst asynchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module uop_link_port_assertions
  import uop_pkg::*;
(
  // System.
  input wire logic mclk,
  input wire logic rst,
  // Link and streams.
  input wire logic [7:0] link_data_o,
  input wire logic link_data_oe,
  input wire logic link_stp,
  input wire logic tx_valid,
  input wire logic tx_take,
  input wire logic rx_valid,
  input wire logic rx_active,
  input wire logic reg_req,
  input wire logic reg_busy,
  // Configuration.
  input wire logic host_mode,
  input wire logic [1:0] speed_req,
  input wire logic [CNT_W-1:0] chan_used,
  input wire logic [CNT_W-1:0] per_in_used,
  input wire logic [1:0] speed_eff,
  input wire logic limit_err,
  input wire logic attach_detection,
  input wire logic attached
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_idle_low;
    link_stp || $fell(rx_active) |-> link_data_oe && link_data_o == DATA_IDLE;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("bus not low in idle");
  property p_stp_len; $rose(link_stp) |=> link_stp [*5] ##[1:5] !link_stp; endproperty
  a_stp_len: assert property (p_stp_len) else $error("stop length wrong");
  property p_take_gap; tx_take |=> !tx_take [*5]; endproperty
  a_take_gap: assert property (p_take_gap) else $error("bytes too close");
  property p_rx_free; rx_active |-> !link_data_oe; endproperty
  a_rx_free: assert property (p_rx_free) else $error("bus driven in receive");
  property p_turn; $rose(rx_active) |-> !rx_valid ##1 !rx_valid [*5]; endproperty
  a_turn: assert property (p_turn) else $error("sample in turnaround");
  property p_speed;
    speed_req != 2'h3 |=> speed_eff ==
      (!$past(host_mode) && $past(speed_req) == SPD_LOW ? SPD_FULL : $past(speed_req));
  endproperty
  a_speed: assert property (p_speed) else $error("speed wrong");
  property p_over;
    (host_mode && chan_used > MAX_HOST_CHANNELS_C) ||
      (!host_mode && per_in_used > MAX_PERIODIC_IN_C) |=> limit_err;
  endproperty
  a_over: assert property (p_over) else $error("limit not flagged");
  property p_attach; attach_detection [*5] |-> attached; endproperty
  a_attach: assert property (p_attach) else $error("attach not seen");
  cover property (tx_take ##[1:20] tx_take);
  cover property ($rose(rx_active) ##[1:40] rx_valid);
  cover property ($rose(link_stp));
endmodule // uop_link_port_assertions
bind uop_link_port uop_link_port_assertions uop_link_port_assertions_inst (.*);
`default_nettype wire

// File: bench/uop_link_port_tb.sv
// Bench for the link port: user-side scenarios against the transceiver model.
// Assumes the model accepts every nonzero byte and sends a frame on request.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module uop_link_port_tb;
  import uop_pkg::*;
  logic mclk, rst, link_clk, link_dir, link_nxt, link_data_oe, link_stp, rx_go;
  logic tx_valid, tx_last, tx_take, tx_abort, rx_valid, rx_is_cmd, rx_active, pull_req;
  logic reg_req, reg_write, reg_done, reg_busy, host_mode, limit_err, attach_detection, attached;
  logic [7:0] link_data_i, link_data_o, tx_data, rx_data, reg_wdata, reg_rdata;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [1:0] speed_req, speed_eff;
  logic [CNT_W-1:0] chan_used, ep_used, per_in_used;
  logic [23:0] acc_q;
  int fail_count, n_tests;
  uop_link_port uop_link_port_inst (.*);
  uop_phy_model uop_phy_model_inst (.*);
  always #50 mclk = ~mclk;
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wait_hi(ref logic s);
    int n = 0;
    while (s !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    `CHK(s, 1'b1)
  endtask
  task automatic t_tx();
    logic [7:0] b [3] = '{8'h41, 8'h11, 8'h22};
    for (int i = 0; i < 3; i++) begin
      tx_data = b[i];
      tx_last = (i == 2);
      tx_valid = 1'b1;
      wait_hi(tx_take);
      step(1);
    end
    {tx_valid, tx_last} = '0;
    wait_hi(link_stp);
    `CHK(link_data_o, DATA_IDLE)
    `CHK(acc_q, {8'h41, 8'h11, 8'h22})
    step(12);
  endtask
  task automatic t_reg(input logic wr, input logic [REG_ADDR_W-1:0] a);
    reg_write = wr;
    reg_addr = a;
    reg_req = 1'b1;
    step(1);
    reg_req = 1'b0;
    `CHK(reg_busy, 1'b1)
    wait_hi(reg_done);
    `CHK(reg_busy, 1'b0)
    step(12);
  endtask
  task automatic t_regs();
    reg_wdata = 8'h96;
    t_reg(1'b1, 6'h2A);
    `CHK(acc_q[15:0], {CMD_REG_WRITE, 6'h2A, 8'h96})
    t_reg(1'b0, 6'h15);
    `CHK(reg_rdata, 8'h51)
  endtask
  task automatic t_rx();
    logic [8:0] got [$];
    rx_go = 1'b1;
    wait_hi(rx_active);
    `CHK(link_data_oe, 1'b0)
    rx_go = 1'b0;
    repeat (60) begin
      @(negedge mclk);
      if (rx_valid)
        got.push_back({rx_is_cmd, rx_data});
    end
    `CHK(got.size(), 3)
    `CHK(got[0], {1'b1, 8'h53})
    `CHK(got[1], {1'b0, 8'h52})
    `CHK(got[2], {1'b0, 8'h51})
  endtask
  task automatic t_abort();
    tx_data = 8'h41;
    tx_valid = 1'b1;
    wait_hi(tx_take);
    tx_data = 8'h33;
    rx_go = 1'b1;
    wait_hi(tx_abort);
    tx_valid = 1'b0;
    wait_hi(rx_active);
    rx_go = 1'b0;
    step(60);
  endtask
  task automatic t_pull();
    pull_req = 1'b1;
    step(1);
    pull_req = 1'b0;
    wait_hi(link_stp);
    `CHK(link_data_o, DATA_IDLE)
    step(12);
  endtask
  task automatic t_cfg();
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 3; s++) begin
        host_mode = m[0];
        speed_req = s[1:0];
        step(3);
        `CHK(speed_eff, (!m[0] && s[1:0] == SPD_LOW) ? SPD_FULL : s[1:0])
      end
    end
    speed_req = 2'h3;
    step(3);
    `CHK(speed_eff, SPD_LOW)
    chan_used = 5'h11;
    step(3);
    `CHK(limit_err, 1'b1)
    {chan_used, ep_used} = {5'h10, 5'h10};
    step(3);
    `CHK(limit_err, 1'b0)
    host_mode = 1'b0;
    per_in_used = 5'h08;
    step(3);
    `CHK(limit_err, 1'b1)
    {per_in_used, ep_used} = {5'h07, 5'h11};
    step(3);
    `CHK(limit_err, 1'b1)
    attach_detection = 1'b1;
    step(6);
    `CHK(attached, 1'b1)
  endtask
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {rx_go, tx_valid, tx_last, pull_req, reg_req, reg_write, host_mode, attach_detection} = '0;
    {tx_data, reg_wdata, reg_addr, speed_req, chan_used, ep_used, per_in_used} = '0;
    step(20);
    `CHK(link_data_o, DATA_IDLE)
    `CHK(link_data_oe, 1'b1)
    `CHK(speed_eff, SPEED_RST)
    rst = 1'b0;
    step(20);
    t_tx();
    t_regs();
    t_rx();
    t_abort();
    t_pull();
    t_cfg();
    summarize();
  end
  // The scenarios need about 400 cycles; the limit leaves a wide margin.
  initial begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    summarize();
  end
endmodule // uop_link_port_tb
`default_nettype wire
